//--- rtl/crie_regs.vh
// register map, field positions and reset values of the receive irq enables
`ifndef CRIE_REGS_VH
`define CRIE_REGS_VH
`define CRIE_ADDR_W 4
`define CRIE_OFS_ENABLE 4'h0
`define CRIE_OFS_FLAGS 4'h4
`define CRIE_OFS_CTRL 4'h8
`define CRIE_OFS_IRQMASK 4'hc
`define CRIE_BIT_WAKE 7
`define CRIE_BIT_BSC 6
`define CRIE_RXSEL_HI 5
`define CRIE_RXSEL_LO 4
`define CRIE_TXSEL_HI 3
`define CRIE_TXSEL_LO 2
`define CRIE_BIT_OVR 1
`define CRIE_BIT_RXF 0
`define CRIE_EN_RESET 8'h00
`define CRIE_SEL_RESET 2'h0
`define CRIE_CTRL_INIT_REQ 0
`define CRIE_CTRL_INIT_ACK 1
`define CRIE_CTRL_WUPFE 2
`define CRIE_REC_WARN 9'h060
`define CRIE_REC_PASSIVE 9'h07f
`define CRIE_TEC_OFF 9'h0ff
`define CRIE_ST_OK 2'h0
`define CRIE_ST_WARN 2'h1
`define CRIE_ST_PASSIVE 2'h2
`define CRIE_ST_OFF 2'h3
`endif

//--- rtl/crie_rx_irq_enable.v
// receive-side interrupt enables, state-change sensitivity and apb slave
`timescale 1ns/1ps
`include "crie_regs.vh"
module crie_rx_irq_enable #(
    parameter CNT_W = 9
) (
    input wire clk_sys,
    input wire reset_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [CNT_W-1:0] rxErrCount,
    input wire [CNT_W-1:0] txErrCount,
    input wire wakeupEvent,
    input wire overrunEvent,
    input wire receiveFullSet,
    input wire receiveFullClear,
    output reg wakeupIrq,
    output reg errorIrq,
    output reg receiveIrq,
    output reg irq
);
    // enable register fields
    reg wakeupIrqEnable_q;
    reg busStateChangeIrqEnable_q;
    reg overrunIrqEnable_q;
    reg receiveFullIrqEnable_q;
    reg [1:0] rxSens_q;
    reg [1:0] txSens_q;
    // control: init request, acknowledge, wake-up function enable
    reg initRequest_q;
    reg initAck_q;
    reg wakeupFunctionEnable_q;
    // flags
    reg wakeupFlag_q;
    reg busStateChangeFlag_q;
    reg overrunFlag_q;
    reg receiveFullFlag_q;
    reg [1:0] rxBusState_q;
    reg [1:0] txBusState_q;
    reg [3:0] irqMask_q;
    reg [1:0] rxNow;
    reg [1:0] txNow;
    reg rxHit;
    reg txHit;

    wire [3:0] wOfs = paddr[`CRIE_ADDR_W-1:0];
    wire mapped = (paddr[31:`CRIE_ADDR_W] == 28'h0000000) &&
        (wOfs == `CRIE_OFS_ENABLE || wOfs == `CRIE_OFS_FLAGS ||
        wOfs == `CRIE_OFS_CTRL || wOfs == `CRIE_OFS_IRQMASK);
    wire access = psel && penable && pready;
    wire wr = access && pwrite && mapped;
    wire inInit = initRequest_q && initAck_q;
    wire wrEnable = wr && (wOfs == `CRIE_OFS_ENABLE) &&
        !initRequest_q && !initAck_q;
    wire wrFlags = wr && (wOfs == `CRIE_OFS_FLAGS);
    wire [7:0] enableWord = {wakeupIrqEnable_q, busStateChangeIrqEnable_q,
        rxSens_q, txSens_q, overrunIrqEnable_q, receiveFullIrqEnable_q};
    wire [7:0] flagWord = {wakeupFlag_q, busStateChangeFlag_q, rxBusState_q,
        txBusState_q, overrunFlag_q, receiveFullFlag_q};
    wire wakeSet = wakeupEvent && wakeupFunctionEnable_q;
    wire [3:0] evNow = {wakeupIrq, errorIrq, receiveIrq, 1'b0};

    // live bus state from the error counters
    always @* begin
        if (txErrCount > `CRIE_TEC_OFF) begin
            rxNow = `CRIE_ST_OFF;
            txNow = `CRIE_ST_OFF;
        end else begin
            if (rxErrCount > `CRIE_REC_PASSIVE)
                rxNow = `CRIE_ST_PASSIVE;
            else if (rxErrCount > `CRIE_REC_WARN)
                rxNow = `CRIE_ST_WARN;
            else
                rxNow = `CRIE_ST_OK;
            if (txErrCount > `CRIE_REC_PASSIVE)
                txNow = `CRIE_ST_PASSIVE;
            else if (txErrCount > `CRIE_REC_WARN)
                txNow = `CRIE_ST_WARN;
            else
                txNow = `CRIE_ST_OK;
        end
    end

    // sensitivity filter on a state change
    function sens_hit;
        input [1:0] sel;
        input [1:0] oldSt;
        input [1:0] newSt;
        begin
            case (sel)
                2'h0: sens_hit = 1'b0;
                2'h1: sens_hit = (oldSt == `CRIE_ST_OFF) !=
                    (newSt == `CRIE_ST_OFF);
                2'h2: sens_hit = (oldSt[1] != newSt[1]);
                default: sens_hit = (oldSt != newSt);
            endcase
        end
    endfunction

    always @* begin
        rxHit = sens_hit(rxSens_q, rxBusState_q, rxNow);
        txHit = sens_hit(txSens_q, txBusState_q, txNow);
    end

    // enable register: held in reset during init except selectors
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wakeupIrqEnable_q <= 1'b0;
            busStateChangeIrqEnable_q <= 1'b0;
            overrunIrqEnable_q <= 1'b0;
            receiveFullIrqEnable_q <= 1'b0;
            rxSens_q <= `CRIE_SEL_RESET;
            txSens_q <= `CRIE_SEL_RESET;
        end else if (inInit) begin
            wakeupIrqEnable_q <= 1'b0;
            busStateChangeIrqEnable_q <= 1'b0;
            overrunIrqEnable_q <= 1'b0;
            receiveFullIrqEnable_q <= 1'b0;
        end else if (wrEnable) begin
            wakeupIrqEnable_q <= pwdata[`CRIE_BIT_WAKE];
            busStateChangeIrqEnable_q <= pwdata[`CRIE_BIT_BSC];
            rxSens_q <= pwdata[`CRIE_RXSEL_HI:`CRIE_RXSEL_LO];
            txSens_q <= pwdata[`CRIE_TXSEL_HI:`CRIE_TXSEL_LO];
            overrunIrqEnable_q <= pwdata[`CRIE_BIT_OVR];
            receiveFullIrqEnable_q <= pwdata[`CRIE_BIT_RXF];
        end
    end

    // control register; acknowledge follows request one cycle later
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            initRequest_q <= 1'b0;
            initAck_q <= 1'b0;
            wakeupFunctionEnable_q <= 1'b0;
            irqMask_q <= 4'h0;
        end else begin
            initAck_q <= initRequest_q;
            if (wr && wOfs == `CRIE_OFS_CTRL) begin
                initRequest_q <= pwdata[`CRIE_CTRL_INIT_REQ];
                wakeupFunctionEnable_q <= pwdata[`CRIE_CTRL_WUPFE];
            end
            if (wr && wOfs == `CRIE_OFS_IRQMASK)
                irqMask_q <= pwdata[3:0];
        end
    end

    // flags: hardware set wins over write-one-to-clear
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wakeupFlag_q <= 1'b0;
            busStateChangeFlag_q <= 1'b0;
            overrunFlag_q <= 1'b0;
            receiveFullFlag_q <= 1'b0;
            rxBusState_q <= `CRIE_ST_OK;
            txBusState_q <= `CRIE_ST_OK;
        end else begin
            if (wakeSet)
                wakeupFlag_q <= 1'b1;
            else if (wrFlags && pwdata[`CRIE_BIT_WAKE])
                wakeupFlag_q <= 1'b0;
            if (overrunEvent)
                overrunFlag_q <= 1'b1;
            else if (wrFlags && pwdata[`CRIE_BIT_OVR])
                overrunFlag_q <= 1'b0;
            if (receiveFullSet)
                receiveFullFlag_q <= 1'b1;
            else if (receiveFullClear ||
                (wrFlags && pwdata[`CRIE_BIT_RXF]))
                receiveFullFlag_q <= 1'b0;
            // state bits frozen while a status change is pending
            if (!busStateChangeFlag_q) begin
                rxBusState_q <= rxNow;
                txBusState_q <= txNow;
                if (rxHit || txHit)
                    busStateChangeFlag_q <= 1'b1;
            end else if (wrFlags && pwdata[`CRIE_BIT_BSC]) begin
                busStateChangeFlag_q <= 1'b0;
            end
        end
    end

    // request lines are levels from flag and enable, irq from the masked request lines
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wakeupIrq <= 1'b0;
            errorIrq <= 1'b0;
            receiveIrq <= 1'b0;
            irq <= 1'b0;
        end else begin
            wakeupIrq <= wakeupFlag_q && wakeupIrqEnable_q;
            errorIrq <= (busStateChangeFlag_q && busStateChangeIrqEnable_q)
                || (overrunFlag_q && overrunIrqEnable_q);
            receiveIrq <= receiveFullFlag_q
                && receiveFullIrqEnable_q;
            irq <= |(evNow & irqMask_q);
        end
    end

    // apb slave: one wait state, read data registered
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            if (psel && penable && !pready && !pwrite) begin
                case (wOfs)
                    `CRIE_OFS_ENABLE: prdata <= {24'h000000, enableWord};
                    `CRIE_OFS_FLAGS: prdata <= {24'h000000, flagWord};
                    `CRIE_OFS_CTRL: prdata <= {29'h00000000,
                        wakeupFunctionEnable_q, initAck_q, initRequest_q};
                    `CRIE_OFS_IRQMASK: prdata <= {28'h0000000, irqMask_q};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

//--- testbench/crie_rx_irq_properties.sv
// port-level assertions for the receive irq enable block
`timescale 1ns/1ps
module crie_rx_irq_properties (
    input wire clk_sys,
    input wire reset_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire wakeupEvent,
    input wire receiveFullSet,
    input wire receiveFullClear,
    input wire wakeupIrq,
    input wire errorIrq,
    input wire receiveIrq,
    input wire irq
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    reg [4:0] busHist_q;
    wire busQuiet = ~|busHist_q;
    // recent bus activity, all ones out of reset so reset effects are excused
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) busHist_q <= 5'h1f;
        else busHist_q <= {busHist_q[3:0], psel};
    end
    wait_state_a: assert property (psel && penable && !pready |=> pready)
        else $error("ready missing after one wait state");
    ready_in_access_a: assert property (pready |-> psel && penable
        && $past(psel && penable && !pready)) else $error("stray ready");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error response without ready");
    rdata_hold_a: assert property (!$stable(prdata) |-> pready && !pwrite)
        else $error("read data moved outside a read");
    rx_irq_level_a: assert property ($fell(receiveIrq) |->
        $past(receiveFullClear, 2) || !busQuiet) else $error("rx request drop");
    rx_irq_cause_a: assert property ($rose(receiveIrq) |->
        $past(receiveFullSet, 2) || !busQuiet) else $error("rx request rise");
    wake_irq_cause_a: assert property ($rose(wakeupIrq) |->
        $past(wakeupEvent, 2) || !busQuiet) else $error("wake request rise");
    err_irq_drop_a: assert property ($fell(errorIrq) |-> !busQuiet)
        else $error("error request dropped without software");
    irq_source_a: assert property (irq |-> wakeupIrq || errorIrq
        || receiveIrq || $past(wakeupIrq || errorIrq || receiveIrq))
        else $error("irq without request");
endmodule
bind crie_rx_irq_enable crie_rx_irq_properties chk (.*);

//--- testbench/crie_rx_irq_enable_tb.sv
// self-checking bench for the receive irq enable block
`timescale 1ns/1ps
module crie_rx_irq_enable_tb;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [8:0] rxErrCount = 9'h0;
    logic [8:0] txErrCount = 9'h0;
    logic wakeupEvent = 1'b0;
    logic overrunEvent = 1'b0;
    logic receiveFullSet = 1'b0;
    logic receiveFullClear = 1'b0;
    wire [31:0] prdata;
    wire pready, pslverr, wakeupIrq, errorIrq, receiveIrq, irq;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic ok;
    crie_rx_irq_enable uut (.*);
    // 50 MHz clock
    always #10 clk_sys = ~clk_sys;
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, held until ready is sampled high
    task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        ok = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one-cycle pulses: rx clear, wake, overrun, rx full
    task kick(input logic [3:0] ev);
        @(posedge clk_sys);
        {receiveFullClear, wakeupEvent, overrunEvent, receiveFullSet} <= ev;
        @(posedge clk_sys);
        {receiveFullClear, wakeupEvent, overrunEvent, receiveFullSet} <= 4'h0;
        repeat (3) @(posedge clk_sys);
    endtask
    task t_regs;
        apb(0, 32'h0, 0);
        check(rd, 32'h0);
        apb(0, 32'h10, 0);
        check(ok, 1'b1);
        $display("test regs done");
    endtask
    task t_gate;
        apb(1, 32'hc, 32'he);
        apb(1, 32'h8, 32'h4);
        for (int i = 0; i < 2; i++) begin
            apb(1, 32'h0, i ? 32'h83 : 32'h0);
            kick(4'h7);
            check({wakeupIrq, errorIrq, receiveIrq}, i ? 3'h7 : 3'h0);
            check(irq, i);
        end
        repeat (20) @(posedge clk_sys);
        check(receiveIrq, 1'b1);
        apb(1, 32'hc, 32'h0);
        repeat (2) @(posedge clk_sys);
        check(irq, 1'b0);
        kick(4'h8);
        check(receiveIrq, 1'b0);
        apb(1, 32'h4, 32'h82);
        repeat (2) @(posedge clk_sys);
        check({wakeupIrq, errorIrq}, 2'h0);
        $display("test gating done");
    endtask
    task t_init;
        apb(1, 32'h0, 32'hff);
        apb(1, 32'h8, 32'h5);
        repeat (3) @(posedge clk_sys);
        apb(0, 32'h0, 0);
        check(rd, 32'h3c);
        apb(1, 32'h0, 32'h83);
        apb(0, 32'h0, 0);
        check(rd, 32'h3c);
        apb(1, 32'h8, 32'h4);
        repeat (3) @(posedge clk_sys);
        apb(0, 32'h0, 0);
        check(rd, 32'h3c);
        apb(1, 32'h0, 32'h0);
        apb(0, 32'h0, 0);
        check(rd, 32'h0);
        $display("test init done");
    endtask
    // move one error count from zero under a chosen sensitivity
    task sens(input logic tx, input logic [1:0] sel, input logic [8:0] cnt,
            input logic exp);
        logic [1:0] st;
        st = cnt > 127 ? 2'h2 : cnt > 96 ? 2'h1 : 2'h0;
        apb(1, 32'h0, 32'h0);
        rxErrCount <= 9'h0;
        txErrCount <= 9'h0;
        repeat (3) @(posedge clk_sys);
        apb(1, 32'h4, 32'hc3);
        apb(1, 32'h0, {24'h0, 2'h1, tx ? {2'h0, sel} : {sel, 2'h0}, 2'h0});
        if (tx) txErrCount <= cnt;
        else rxErrCount <= cnt;
        repeat (4) @(posedge clk_sys);
        check(errorIrq, exp);
        apb(0, 32'h4, 0);
        check(rd[5:2], tx ? {2'h0, st} : {st, 2'h0});
    endtask
    task t_sens;
        sens(0, 2'h0, 9'd128, 0);
        sens(0, 2'h1, 9'd128, 0);
        sens(0, 2'h2, 9'd100, 0);
        sens(0, 2'h2, 9'd128, 1);
        sens(0, 2'h3, 9'd100, 1);
        sens(1, 2'h2, 9'd128, 1);
        txErrCount <= 9'd100;
        repeat (3) @(posedge clk_sys);
        apb(0, 32'h4, 0);
        check(rd[3:2], 2'h2);
        sens(1, 2'h1, 9'd100, 0);
        $display("test sensitivity done");
    endtask
    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            finish_test;
        end
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_regs;
        t_gate;
        t_init;
        t_sens;
        finish_test;
    end
endmodule
